/* File: logic/adm_pkg.sv */
package adm_pkg;
  // Control word layout: address above data
  localparam int CW_BITS = 16;
  localparam int CW_ADDR_LSB = 9;
  localparam int REG_BITS = 9;
  // Register addresses on the control port
  localparam logic [6:0] REG_CH_CTRL = 7'h02;
  localparam logic [6:0] REG_FMT_PHASE = 7'h03;
  localparam logic [6:0] REG_MUTE_ZERO = 7'h09;
  localparam logic [6:0] REG_ADC_SIL = 7'h0c;
  // Reset values
  localparam logic [8:0] RST_CH_CTRL = 9'h120;
  localparam logic [8:0] RST_FMT_PHASE = 9'h000;
  localparam logic [8:0] RST_MUTE_ZERO = 9'h000;
  localparam logic [8:0] RST_ADC_SIL = 9'h000;
  // dac_channel_control fields
  localparam int CH_GMUTE = 0;
  localparam int CH_DAC_POWERDOWN = 2;
  localparam int CH_ROUTE_LSB = 5;
  // dac_input_format_and_phase fields
  localparam int FP_FMT_LSB = 0;
  localparam int FP_POL = 2;
  localparam int FP_BCLK_INV = 3;
  localparam int FP_WL_LSB = 4;
  localparam int FP_PHASE_LSB = 6;
  // dac_mute_and_zero_flag fields
  localparam int MZ_ZCD = 0;
  localparam int MZ_SEL_LSB = 1;
  localparam int MZ_MUTE_LSB = 3;
  // adc_silence_control fields
  localparam int AS_RIGHT = 0;
  localparam int AS_LEFT = 1;
  localparam int AS_BOTH = 2;
  // Serial formats, in register code order
  typedef enum logic [1:0] {FMT_RJ, FMT_LJ, FMT_I2S, FMT_DSP} adm_fmt_t;
  // Word length codes
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_24 = 2'h2;
  localparam logic [1:0] WL_32 = 2'h3;
  // Sample widths
  localparam int FILT_BITS = 24;
  localparam int SLOT_BITS = 32;
  // Soft mute gain ramp: full scale and shift
  localparam int GAIN_MAX = 16;
  localparam int GAIN_SHIFT = 4;
  // Zero run length for the flag pin
  localparam int ZERO_RUN = 1024;
  // Timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int BCLK_PERIOD_NS = 320;
  localparam int BCLK_HALF_CYC = BCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int CTL_HALF_NS = 160;
  localparam int CTL_HALF_CYC = CTL_HALF_NS / CLK_PERIOD_NS;
endpackage

/* File: logic/adm_link_if.sv */
`timescale 1ns/1ns
interface adm_link_if;
  // Audio link
  logic dac_bit_clock;
  logic dac_frame_clock;
  logic [2:0] serial_sample_inputs;
  // Control port
  logic control_serial_clock;
  logic control_serial_data;
  logic control_latch;
  // Status pin
  logic zero_flag_pin;

  // Codec end
  modport dev (
    input dac_bit_clock, dac_frame_clock, serial_sample_inputs,
    input control_serial_clock, control_serial_data, control_latch,
    output zero_flag_pin
  );
  // Audio source end
  modport src (
    output dac_bit_clock, dac_frame_clock, serial_sample_inputs,
    output control_serial_clock, control_serial_data, control_latch,
    input zero_flag_pin
  );
endinterface

/* File: logic/adm_dev.sv */
// Functional notes
// - Format code picks RJ, LJ, I2S, DSP
// - Polarity bit inverts frame clock sense
// - In DSP, polarity bit picks A/B
// - Swapping channels adds one-sample phase offset
// - Sample on rising bit clock by default
// - Invert bit moves sampling to falling edge
// - Word length code: 16,20,24,32 bits
// - Right justified 32 falls back to 24
// - Filters get 24 bits, short words zero-filled
// - 32-bit words drop eight low bits
// - Source holds I2S halves at least 24 clocks
// - Phase bit n inverts pair n+1
// - Gain steps wait for zero crossing unless disabled
// - Zero pin after 1024 zero samples
// - Selector: all, channel 1, 2, 3
// - Per-pair soft mute bits combine freely
// - Global bit soft-mutes every pair
// - Routing-off and powerdown silence abruptly
// - ADC silence: right, left, both
// - Control word: 7 address, 9 data bits
// - Latch rising edge commits the word
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
module adm_dev (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link to the audio source
  adm_link_if.dev link,
  // Filter-side samples
  output logic pair_valid,
  output logic [2:0][23:0] pair_left,
  output logic [2:0][23:0] pair_right,
  // ADC input silencing
  output logic adc_left_mute,
  output logic adc_right_mute
);
  localparam int ZW = $clog2(adm_pkg::ZERO_RUN + 1);

  // Bits per word for a code; right justified cannot carry 32
  function automatic logic [6:0] word_bits(logic [1:0] wl, logic rj);
    if (wl == adm_pkg::WL_16) begin
      return 7'h10;
    end else if (wl == adm_pkg::WL_20) begin
      return 7'h14;
    end else if (wl == adm_pkg::WL_24 || rj) begin
      return 7'h18;
    end
    return 7'h20;
  endfunction

  // Right-aligned word to filter width
  function automatic logic [23:0] to_filt(logic [31:0] w, logic [6:0] n);
    if (n == 7'h10) begin
      return {w[15:0], 8'h00};
    end else if (n == 7'h14) begin
      return {w[19:0], 4'h0};
    end else if (n == 7'h18) begin
      return w[23:0];
    end
    return w[31:8];
  endfunction

  // Two-flop synchronisers plus one stage for edge finding
  logic [7:0] s1_q, s2_q, s3_q;
  wire [7:0] pins = {link.control_latch, link.control_serial_data,
    link.control_serial_clock, link.serial_sample_inputs,
    link.dac_frame_clock, link.dac_bit_clock};
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
    end else if (ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Registers
  logic [8:0] ch_q, fp_q, mz_q, adc_q;
  logic [15:0] cw_q; // Control shift register

  // Control port edges
  wire cclk_rise = s2_q[5] & ~s3_q[5];
  wire lat_rise = s2_q[7] & ~s3_q[7];
  wire [6:0] cw_addr = cw_q[15:adm_pkg::CW_ADDR_LSB];
  wire [8:0] cw_data = cw_q[adm_pkg::REG_BITS-1:0];

  // Control word shift and commit
  always_ff @(posedge clk) begin
    if (rst) begin
      cw_q <= 16'h0000;
      ch_q <= adm_pkg::RST_CH_CTRL;
      fp_q <= adm_pkg::RST_FMT_PHASE;
      mz_q <= adm_pkg::RST_MUTE_ZERO;
      adc_q <= adm_pkg::RST_ADC_SIL;
    end else if (ce) begin
      if (cclk_rise) begin
        cw_q <= {cw_q[14:0], s2_q[6]};
      end
      // Unknown addresses are dropped
      if (lat_rise) begin
        if (cw_addr == adm_pkg::REG_CH_CTRL) begin
          ch_q <= cw_data;
        end else if (cw_addr == adm_pkg::REG_FMT_PHASE) begin
          fp_q <= cw_data;
        end else if (cw_addr == adm_pkg::REG_MUTE_ZERO) begin
          mz_q <= cw_data;
        end else if (cw_addr == adm_pkg::REG_ADC_SIL) begin
          adc_q <= cw_data;
        end
      end
    end
  end

  // Field views
  wire [1:0] fmt = fp_q[adm_pkg::FP_FMT_LSB +: 2];
  wire pol = fp_q[adm_pkg::FP_POL];
  wire is_rj = fmt == adm_pkg::FMT_RJ;
  wire is_lj = fmt == adm_pkg::FMT_LJ;
  wire is_i2s = fmt == adm_pkg::FMT_I2S;
  wire is_dsp = fmt == adm_pkg::FMT_DSP;
  wire [6:0] nb = word_bits(fp_q[adm_pkg::FP_WL_LSB +: 2], is_rj);

  // Bit clock sampling edge
  wire bclk_rise = s2_q[0] & ~s3_q[0];
  wire bclk_fall = ~s2_q[0] & s3_q[0];
  wire samp = fp_q[adm_pkg::FP_BCLK_INV] ? bclk_fall : bclk_rise;

  // Frame tracking
  logic lr_prev_q, pend_q;
  logic [6:0] cnt_q;
  wire lr = s2_q[1];
  wire din_chg = lr ^ lr_prev_q;
  wire din_rise = lr & ~lr_prev_q;
  // LJ and DSP B start on this bit, I2S and DSP A on the next
  wire start_now = (is_lj & din_chg) | (is_dsp & pol & din_rise);
  wire start_next = (is_i2s & din_chg) | (is_dsp & ~pol & din_rise);
  wire first = start_now | pend_q;
  wire [6:0] cnt_inc = (cnt_q == 7'h7f) ? cnt_q : cnt_q + 7'h01;
  wire [6:0] idx = first ? 7'h00 : cnt_inc;
  // Channel from frame level; I2S looks one bit back (32-bit last bit)
  wire cur_left = ((is_i2s ? lr_prev_q : lr) ^ pol) == ~is_i2s;
  // Capture points per format
  wire cap_mid = is_dsp ? (idx == nb - 7'h01 || idx == {nb[5:0], 1'b0} - 7'h01)
                        : (idx == nb - 7'h01);
  wire cap = samp & (is_rj ? din_chg : cap_mid);
  wire cap_left = is_rj ? ~cur_left
                : is_dsp ? (idx == nb - 7'h01) : cur_left;
  // Pair is emitted with its right word; a swapped frame clock
  // therefore pairs left of one frame with right of the previous
  wire new_pair = cap & ~cap_left;

  always_ff @(posedge clk) begin
    if (rst) begin
      lr_prev_q <= 1'b0;
      pend_q <= 1'b0;
      cnt_q <= 7'h7f;
    end else if (ce && samp) begin
      lr_prev_q <= lr;
      pend_q <= start_next;
      cnt_q <= idx;
    end
  end

  // Gain and output state
  logic [2:0][31:0] sr_q;
  logic [2:0][23:0] hold_l_q;
  logic [2:0] flag_w;
  logic zflag_q;
  wire [2:0] phase = fp_q[adm_pkg::FP_PHASE_LSB +: 3];
  wire [2:0] pmute = mz_q[adm_pkg::MZ_MUTE_LSB +: 3];
  wire [1:0] zsel = mz_q[adm_pkg::MZ_SEL_LSB +: 2];
  wire [3:0] route = ch_q[adm_pkg::CH_ROUTE_LSB +: 4];

  // Routed selection for one output
  function automatic logic [23:0] pick(logic [1:0] s, logic [23:0] l,
                                       logic [23:0] r);
    logic [24:0] sum;
    sum = {l[23], l} + {r[23], r};
    if (s == 2'h1) begin
      return l;
    end else if (s == 2'h2) begin
      return r;
    end else if (s == 2'h3) begin
      return sum[24:1];
    end
    return 24'h00_0000;
  endfunction

  // Gain scaling by 0..full in steps
  function automatic logic [23:0] scale(logic [23:0] x, logic [4:0] g);
    logic signed [29:0] p;
    p = $signed({{6{x[23]}}, x}) * $signed({25'h000_0000, g});
    return p[adm_pkg::GAIN_SHIFT +: 24];
  endfunction

  for (genvar p = 0; p < 3; p++) begin : g_pair
    logic [4:0] gain_q;
    logic sign_q;
    logic [ZW-1:0] zc_q;
    wire [31:0] sh = {sr_q[p][30:0], s2_q[2+p]};
    wire [23:0] word = to_filt(is_rj ? sr_q[p] : sh, nb);
    wire [23:0] l0 = phase[p] ? -hold_l_q[p] : hold_l_q[p];
    wire [23:0] r0 = phase[p] ? -word : word;
    wire [23:0] lo = pick(route[1:0], l0, r0);
    wire [23:0] ro = pick(route[3:2], l0, r0);
    // Soft mute target, per pair and global
    wire muted = pmute[p] | ch_q[adm_pkg::CH_GMUTE];
    // Gain steps only where the signal crosses zero, unless the MZ_ZCD bit turns the gate off
    wire zc_ok = mz_q[adm_pkg::MZ_ZCD] | (lo == 24'h00_0000)
               | (lo[23] != sign_q);
    wire [4:0] gmax = 5'(adm_pkg::GAIN_MAX);
    wire [4:0] gain_d = (muted && gain_q != 5'h00) ? gain_q - 5'h01
                      : (!muted && gain_q != gmax) ? gain_q + 5'h01
                      : gain_q;
    wire both_zero = (hold_l_q[p] == 24'h00_0000) && (word == 24'h00_0000);
    assign flag_w[p] = zc_q == ZW'(adm_pkg::ZERO_RUN);

    always_ff @(posedge clk) begin
      if (rst) begin
        sr_q[p] <= 32'h0000_0000;
        hold_l_q[p] <= 24'h00_0000;
        gain_q <= 5'(adm_pkg::GAIN_MAX);
        sign_q <= 1'b0;
        zc_q <= '0;
        pair_left[p] <= 24'h00_0000;
        pair_right[p] <= 24'h00_0000;
      end else if (ce && samp) begin
        sr_q[p] <= sh;
        if (cap && cap_left) begin
          hold_l_q[p] <= word;
        end
        if (new_pair) begin
          sign_q <= lo[23];
          if (zc_ok) begin
            gain_q <= gain_d;
          end
          // Count zero pairs up to the run length
          if (!both_zero) begin
            zc_q <= '0;
          end else if (!flag_w[p]) begin
            zc_q <= zc_q + ZW'(1);
          end
          // Powerdown clears at once, no ramp
          if (ch_q[adm_pkg::CH_DAC_POWERDOWN]) begin
            pair_left[p] <= 24'h00_0000;
            pair_right[p] <= 24'h00_0000;
          end else begin
            pair_left[p] <= scale(lo, gain_q);
            pair_right[p] <= scale(ro, gain_q);
          end
        end
      end
    end
  end

  // Flag pin source
  wire zflag_d = (zsel == 2'h0) ? &flag_w : flag_w[zsel - 2'h1];

  // Strobe and pin flops
  always_ff @(posedge clk) begin
    if (rst) begin
      pair_valid <= 1'b0;
      zflag_q <= 1'b0;
      adc_left_mute <= 1'b0;
      adc_right_mute <= 1'b0;
    end else if (ce) begin
      pair_valid <= new_pair & samp;
      zflag_q <= zflag_d;
      adc_left_mute <= adc_q[adm_pkg::AS_LEFT] | adc_q[adm_pkg::AS_BOTH];
      adc_right_mute <= adc_q[adm_pkg::AS_RIGHT] | adc_q[adm_pkg::AS_BOTH];
    end
  end
  assign link.zero_flag_pin = zflag_q;
endmodule

/* File: logic/adm_src.sv */
`timescale 1ns/1ns
module adm_src #(
  parameter int BCLK_HALF = adm_pkg::BCLK_HALF_CYC,
  parameter int CTL_HALF = adm_pkg::CTL_HALF_CYC
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Link to the codec
  adm_link_if.src link,
  // Stream settings, must match the codec
  input wire logic [1:0] fmt,
  input wire logic frame_pol,
  input wire logic bclk_inv,
  input wire logic [1:0] word_len,
  // Samples, right aligned, taken at frame start
  input wire logic [2:0][31:0] smp_left,
  input wire logic [2:0][31:0] smp_right,
  output logic smp_take,
  // Avalon-MM slave: a write to address 0 sends a control word, a read gives status
  input wire logic avs_address,
  input wire logic avs_write,
  input wire logic [15:0] avs_writedata,
  input wire logic avs_read,
  output logic [15:0] avs_readdata,
  output logic avs_waitrequest,
  // Zero flag seen on the pin
  output logic zero_flag
);
  typedef enum logic [1:0] {CS_IDLE, CS_SHIFT, CS_LATCH} adm_cs_t;

  // Frame clock and data bit for slot position k
  function automatic logic [1:0] slot_bits(logic [5:0] k, logic [31:0] l,
                                           logic [31:0] r);
    int n, b;
    logic h;
    logic [31:0] w;
    n = (word_len == adm_pkg::WL_16) ? 16 : (word_len == adm_pkg::WL_20) ? 20
      : (word_len == adm_pkg::WL_24 || fmt == adm_pkg::FMT_RJ) ? 24 : 32;
    h = k[5];
    b = int'(k[4:0]);
    w = h ? r : l;
    if (fmt == adm_pkg::FMT_LJ) begin
      return {~h ^ frame_pol, (b < n) ? w[n-1-b] : 1'b0};
    end else if (fmt == adm_pkg::FMT_I2S) begin
      return {h ^ frame_pol, (b >= 1 && b <= n) ? w[n-b] : 1'b0};
    end else if (fmt == adm_pkg::FMT_RJ) begin
      return {~h ^ frame_pol, (b >= 32 - n) ? w[31-b] : 1'b0};
    end
    // DSP: mode A pulse one bit before data, mode B with it
    b = int'(k);
    return {frame_pol ? (k == 6'h00) : (k == 6'h3f),
            (b < n) ? l[n-1-b] : (b < 2*n) ? r[2*n-1-b] : 1'b0};
  endfunction

  // Bit clock divider and slot counter
  logic [15:0] hc_q;
  logic bclk_q, lr_q;
  logic [5:0] k_q;
  logic [2:0] din_q;
  logic [2:0][31:0] wl_q, wr_q;
  wire half = hc_q == 16'(BCLK_HALF - 1);
  // Launch edge is the one the codec does not sample on
  wire launch = half & (bclk_q != bclk_inv);
  wire [5:0] k_n = k_q + 6'h01;
  wire [2:0][31:0] cl = (k_n == 6'h00) ? smp_left : wl_q;
  wire [2:0][31:0] cr = (k_n == 6'h00) ? smp_right : wr_q;
  wire [1:0] sb0 = slot_bits(k_n, cl[0], cr[0]);
  wire [1:0] sb1 = slot_bits(k_n, cl[1], cr[1]);
  wire [1:0] sb2 = slot_bits(k_n, cl[2], cr[2]);

  always_ff @(posedge clk) begin
    if (rst) begin
      hc_q <= 16'h0000;
      bclk_q <= 1'b0;
      k_q <= 6'h3f;
      lr_q <= 1'b0;
      din_q <= 3'h0;
      wl_q <= '0;
      wr_q <= '0;
      smp_take <= 1'b0;
    end else if (ce) begin
      hc_q <= half ? 16'h0000 : hc_q + 16'h0001;
      smp_take <= launch && k_n == 6'h00;
      if (half) begin
        bclk_q <= ~bclk_q;
      end
      if (launch) begin
        k_q <= k_n;
        wl_q <= cl;
        wr_q <= cr;
        lr_q <= sb0[1];
        din_q <= {sb2[0], sb1[0], sb0[0]};
      end
    end
  end

  // Control port sequencer
  adm_cs_t cs_q;
  logic [15:0] cc_q, cwd_q;
  logic [3:0] bi_q;
  logic cclk_q, cdat_q, clat_q;
  wire ctick = cc_q == 16'(CTL_HALF - 1);
  wire ctl_ready = cs_q == CS_IDLE;
  wire ctl_valid = avs_write & ~avs_address;
  wire [15:0] ctl_word = avs_writedata;
  logic rd_ack_q;
  // Writes stall while a word is still on the wire; reads wait one
  // cycle so the status handed back comes from a flop
  assign avs_waitrequest = (ctl_valid & ~ctl_ready) | (avs_read & ~rd_ack_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_q <= CS_IDLE;
      cc_q <= 16'h0000;
      cwd_q <= 16'h0000;
      bi_q <= 4'h0;
      cclk_q <= 1'b0;
      cdat_q <= 1'b0;
      clat_q <= 1'b0;
    end else if (ce) begin
      cc_q <= (ctick || ctl_ready) ? 16'h0000 : cc_q + 16'h0001;
      case (cs_q)
        CS_IDLE: begin
          if (ctl_valid) begin
            cwd_q <= ctl_word;
            cdat_q <= ctl_word[15];
            bi_q <= 4'hf;
            cs_q <= CS_SHIFT;
          end
        end
        CS_SHIFT: begin
          if (ctick) begin
            cclk_q <= ~cclk_q;
            // Data moves with the falling control clock
            if (cclk_q && bi_q == 4'h0) begin
              cs_q <= CS_LATCH;
            end else if (cclk_q) begin
              bi_q <= bi_q - 4'h1;
              cdat_q <= cwd_q[bi_q - 4'h1];
            end
          end
        end
        default: begin
          if (ctick) begin
            clat_q <= ~clat_q;
            if (clat_q) begin
              cs_q <= CS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Zero flag pin synchroniser and status read flops
  logic zf1_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      zf1_q <= 1'b0;
      zero_flag <= 1'b0;
      rd_ack_q <= 1'b0;
      avs_readdata <= 16'h0000;
    end else if (ce) begin
      zf1_q <= link.zero_flag_pin;
      zero_flag <= zf1_q;
      rd_ack_q <= avs_read & ~rd_ack_q;
      // Status: bit 1 zero flag, bit 0 word still shifting or latching
      if (avs_read && !rd_ack_q) begin
        avs_readdata <= {14'h0, zero_flag, ~ctl_ready};
      end
    end
  end

  assign link.dac_bit_clock = bclk_q;
  assign link.dac_frame_clock = lr_q;
  assign link.serial_sample_inputs = din_q;
  assign link.control_serial_clock = cclk_q;
  assign link.control_serial_data = cdat_q;
  assign link.control_latch = clat_q;
endmodule

/* File: sim/adm_link_sva.sv */
`timescale 1ns/1ns
module adm_link_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Audio link
  input wire logic dac_bit_clock,
  input wire logic dac_frame_clock,
  input wire logic [2:0] serial_sample_inputs,
  // Control port
  input wire logic control_serial_clock,
  input wire logic control_serial_data,
  input wire logic control_latch,
  // Status pin
  input wire logic zero_flag_pin
);
  // Control clock delayed, for edge finding
  logic cclk_q;
  // Rising control clocks since the last latch
  logic [5:0] rise_q;
  logic [5:0] rise_d;
  // Latch clears the count, so each word is counted alone
  assign rise_d = control_latch ? 6'h00 :
    rise_q + {5'h00, control_serial_clock & ~cclk_q};

  // Edge counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cclk_q <= 1'b0;
      rise_q <= 6'h00;
    end else begin
      cclk_q <= control_serial_clock;
      rise_q <= rise_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  chk_data_setup: assert property ($changed(serial_sample_inputs) |=>
    $stable(dac_bit_clock)[*2]) else $error("data moved near bit clock edge");
  chk_frame_setup: assert property ($changed(dac_frame_clock) |=>
    $stable(dac_bit_clock)[*2]) else $error("frame moved near bit clock edge");
  chk_bclk_half: assert property ($changed(dac_bit_clock) |=>
    $stable(dac_bit_clock)[*3]) else $error("bit clock half too short");
  chk_ctl_data: assert property ($rose(control_serial_clock) |->
    $stable(control_serial_data) ##1 $stable(control_serial_data)[*2])
    else $error("control data moved at clock rise");
  chk_cclk_half: assert property ($changed(control_serial_clock) |=>
    $stable(control_serial_clock)[*3]) else $error("control clock too fast");
  chk_word_bits: assert property ($rose(control_latch) |->
    rise_q == 6'd16) else $error("control word not 16 bits");
  chk_latch_width: assert property ($rose(control_latch) |->
    control_latch[*4] ##1 !control_latch) else $error("latch width wrong");
  chk_latch_quiet: assert property (control_latch |->
    !control_serial_clock) else $error("control clock high while latching");

  // Main traffic seen
  cover property ($rose(control_latch));
  cover property ($fell(dac_frame_clock));
  cover property ($changed(serial_sample_inputs));
endmodule

/* File: sim/dac_audio_port_mute_control_bench.sv */
`timescale 1ns/1ns
module dac_audio_port_mute_control_bench;
  // Clock and reset
  logic clk = 1'b0;
  logic rst = 1'b1;
  // Source stream settings and samples
  logic [1:0] fmt = 2'h0;
  logic frame_pol = 1'b0;
  logic bclk_inv = 1'b0;
  logic [1:0] word_len = 2'h0;
  logic [2:0][31:0] smp_left = '0;
  logic [2:0][31:0] smp_right = '0;
  // Avalon-MM master side
  logic avs_address = 1'b0;
  logic avs_write = 1'b0;
  logic [15:0] avs_writedata = 16'h0000;
  logic avs_read = 1'b0;
  logic [15:0] avs_readdata;
  logic avs_waitrequest;
  // Design outputs
  logic smp_take;
  logic zero_flag;
  logic pair_valid;
  logic [2:0][23:0] pair_left;
  logic [2:0][23:0] pair_right;
  logic adc_left_mute;
  logic adc_right_mute;
  // Tallies
  int n_errors = 0;
  int comparisons = 0;
  // Steady samples for the mute tests
  localparam logic [23:0] LV = 24'h12_3456;
  localparam logic [23:0] RV = 24'h54_3210;

  adm_link_if link ();
  adm_src i_adm_src (.clk(clk), .rst(rst), .ce(1'b1), .link(link.src),
    .fmt(fmt), .frame_pol(frame_pol), .bclk_inv(bclk_inv),
    .word_len(word_len), .smp_left(smp_left), .smp_right(smp_right),
    .smp_take(smp_take), .avs_address(avs_address),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_read(avs_read), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .zero_flag(zero_flag));
  adm_dev i_adm_dev (.clk(clk), .rst(rst), .ce(1'b1), .link(link.dev),
    .pair_valid(pair_valid), .pair_left(pair_left),
    .pair_right(pair_right), .adc_left_mute(adc_left_mute),
    .adc_right_mute(adc_right_mute));
  adm_link_sva i_adm_link_sva (.clk(clk), .rst(rst),
    .dac_bit_clock(link.dac_bit_clock),
    .dac_frame_clock(link.dac_frame_clock),
    .serial_sample_inputs(link.serial_sample_inputs),
    .control_serial_clock(link.control_serial_clock),
    .control_serial_data(link.control_serial_data),
    .control_latch(link.control_latch),
    .zero_flag_pin(link.zero_flag_pin));

  // 25 MHz clock
  always #(adm_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  // Value comparison
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Verdict and stop
  task automatic end_sim();
    $display("Errors %0d, comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Filter-side word expected for a right aligned source word
  function automatic logic [31:0] exp24(logic [31:0] w, logic [1:0] f,
    logic [1:0] wl, logic inv);
    logic [23:0] r;
    case (wl)
      2'h0: r = {w[15:0], 8'h00};
      2'h1: r = {w[19:0], 4'h0};
      2'h2: r = w[23:0];
      default: r = (f == 2'h0) ? w[23:0] : w[31:8];
    endcase
    if (inv)
      r = -r;
    return {8'h00, r};
  endfunction

  // Skip k pairs; pair_valid is probed at negedge to dodge edge races
  task automatic wait_pairs(input int k);
    int n;
    repeat (k) begin
      n = 0;
      @(negedge clk);
      while (pair_valid !== 1'b1 && n < 2000) begin
        @(negedge clk);
        n++;
      end
      cmp({31'h0, n < 2000}, 32'h1);
    end
  endtask

  // One status read; data taken at the edge the stall is seen low
  task automatic av_rd(output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= 1'b1;
    avs_read <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_read <= 1'b0;
    cmp({31'h0, n < 100}, 32'h1);
  endtask

  // One control word; write held until the stall drops, then status
  // is polled until the word has left the port
  task automatic ctl_wr(input logic [6:0] a, input logic [8:0] d);
    logic [15:0] st;
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= 1'b0;
    avs_writedata <= {a, d};
    avs_write <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 1000);
    avs_write <= 1'b0;
    do begin
      av_rd(st);
      n++;
    end while (st[0] !== 1'b0 && n < 1000);
    cmp({31'h0, n < 1000}, 32'h1);
    repeat (6) @(posedge clk);
  endtask

  // One stereo pair against expected values
  task automatic chk_pair(input int k, input logic [23:0] l,
    input logic [23:0] r);
    cmp({8'h00, pair_left[k]}, {8'h00, l});
    cmp({8'h00, pair_right[k]}, {8'h00, r});
  endtask

  // ADC silence codes, then an unmapped address that must be ignored
  task automatic s_adc();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      ctl_wr(adm_pkg::REG_ADC_SIL, {6'h00, c});
      cmp({30'h0, adc_left_mute, adc_right_mute},
        {30'h0, c[1] | c[2], c[0] | c[2]});
    end
    ctl_wr(7'h0d, 9'h000);
    cmp({30'h0, adc_left_mute, adc_right_mute}, 32'h3);
  endtask

  // Every format, word length, both polarities and phase patterns
  task automatic s_formats();
    logic [3:0] c;
    logic [31:0] v;
    for (int i = 0; i < 16; i++) begin
      c = 4'(i);
      v = 32'h9abc_def1 + {c, 16'h0000, c, 8'h00};
      ctl_wr(adm_pkg::REG_FMT_PHASE,
        {c[2:0], c[3:2], c[1] ^ c[3], c[0] ^ c[2], c[1:0]});
      @(posedge clk);
      fmt <= c[1:0];
      frame_pol <= c[0] ^ c[2];
      bclk_inv <= c[1] ^ c[3];
      word_len <= c[3:2];
      for (int k = 0; k < 3; k++) begin
        smp_left[k] <= v + 32'(k);
        smp_right[k] <= ~v - 32'(k);
      end
      wait_pairs(3);
      for (int k = 0; k < 3; k++) begin
        cmp({8'h00, pair_left[k]}, exp24(v + 32'(k), c[1:0], c[3:2], c[k]));
        cmp({8'h00, pair_right[k]}, exp24(~v - 32'(k), c[1:0], c[3:2], c[k]));
      end
    end
  endtask

  // Soft mutes, zero-cross gate and abrupt routing silence
  task automatic s_mute();
    ctl_wr(adm_pkg::REG_FMT_PHASE, 9'h021);
    @(posedge clk);
    fmt <= 2'h1;
    frame_pol <= 1'b0;
    bclk_inv <= 1'b0;
    word_len <= 2'h2;
    smp_left <= {3{8'h00, LV}};
    smp_right <= {3{8'h00, RV}};
    ctl_wr(adm_pkg::REG_MUTE_ZERO, 9'h021);
    wait_pairs(2);
    cmp({31'h0, pair_left[2] != LV && pair_left[2] != 24'h0}, 32'h1);
    wait_pairs(18);
    chk_pair(2, 24'h0, 24'h0);
    chk_pair(0, LV, RV);
    // Gate on and a constant signal: release must stall
    ctl_wr(adm_pkg::REG_MUTE_ZERO, 9'h000);
    wait_pairs(18);
    chk_pair(2, 24'h0, 24'h0);
    ctl_wr(adm_pkg::REG_MUTE_ZERO, 9'h001);
    wait_pairs(18);
    chk_pair(2, LV, RV);
    ctl_wr(adm_pkg::REG_CH_CTRL, 9'h121);
    wait_pairs(18);
    chk_pair(1, 24'h0, 24'h0);
    ctl_wr(adm_pkg::REG_CH_CTRL, 9'h120);
    wait_pairs(18);
    chk_pair(1, LV, RV);
    ctl_wr(adm_pkg::REG_CH_CTRL, 9'h020);
    wait_pairs(2);
    chk_pair(0, LV, 24'h0);
    ctl_wr(adm_pkg::REG_CH_CTRL, 9'h120);
    wait_pairs(2);
    chk_pair(0, LV, RV);
    // Powerdown silences on the very next pair, no ramp
    ctl_wr(adm_pkg::REG_CH_CTRL, 9'h124);
    wait_pairs(1);
    chk_pair(0, 24'h0, 24'h0);
    ctl_wr(adm_pkg::REG_CH_CTRL, 9'h120);
  endtask

  // Short zero run on pair 1 must not raise the flag
  task automatic s_zero();
    logic [15:0] st;
    @(posedge clk);
    smp_left[0] <= 32'h0000_0000;
    smp_right[0] <= 32'h0000_0000;
    ctl_wr(adm_pkg::REG_MUTE_ZERO, 9'h003);
    wait_pairs(8);
    cmp({30'h0, zero_flag, link.zero_flag_pin}, 32'h0);
    av_rd(st);
    cmp({16'h0000, st}, 32'h0);
  endtask

  // Main sequence
  initial begin
    repeat (15) @(posedge clk);
    @(negedge clk);
    cmp({26'h0, pair_valid, adc_left_mute, adc_right_mute, zero_flag,
      link.control_latch, ~avs_waitrequest}, 32'h1);
    @(posedge clk);
    rst <= 1'b0;
    s_adc();
    s_formats();
    s_mute();
    s_zero();
    end_sim();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (98000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
